// ==== verilog/sset_consts.svh ====
// Purpose: Register offsets, reset values, field positions and timing figures
// Assumes: 100 MHz clock
// Notes: Included by the enable and timing block
`ifndef SSET_CONSTS_SVH
`define SSET_CONSTS_SVH

// ==========================================================================
// Register offsets
`define SSET_ADDR_ENABLE 8'h80
`define SSET_ADDR_INTEG 8'h81
`define SSET_ADDR_PSAMPLE 8'h82
`define SSET_ADDR_LWAIT 8'h83
`define SSET_ADDR_PWAIT 8'hA9

// ==========================================================================
// Reset values
`define SSET_RST_ENABLE 8'h00
`define SSET_RST_INTEG 8'h00
`define SSET_RST_PSAMPLE 8'h1F
`define SSET_RST_LWAIT 8'h00
`define SSET_RST_PWAIT 8'h00

// ==========================================================================
// Enable register fields
`define SSET_EN_OSC 0
`define SSET_EN_LIGHT 1
`define SSET_EN_PROX 2
`define SSET_EN_LWAIT 3
`define SSET_EN_PWAIT 4

// ==========================================================================
// Timing
`define SSET_CLK_PERIOD_NS 10
`define SSET_LIGHT_STEP_NS 2780000
`define SSET_PROX_STEP_NS 88000
`define SSET_LONG_WAIT_MULT 12
`define SSET_COUNT_PER_STEP 1024
`define SSET_COUNT_MAX 16'hFFFF
`define SSET_FULL_SCALE_STEP 8'h3F

`endif

// ==== verilog/sset_pkg.sv ====
// Purpose: Shared types of the enable and timing block
// Assumes: Nothing
// Notes: Constants live in sset_consts.svh
package sset_pkg;
   typedef logic [7:0] sset_byte_t;
   typedef logic [15:0] sset_count_t;
endpackage

// ==== verilog/sset_enable_timing.sv ====
// Purpose: Enable register and measurement timers of a light and proximity sensor
// Assumes: Register port is the internal side of the serial host engine
// Notes: Four repeating down counters, one per timed phase
//
// Summary of operation
// - Enable bit 0 powers the oscillator and converters; while it is low nothing runs.
// - Enable bit 1 turns on the light measurement function.
// - Enable bit 2 turns on the proximity detection function.
// - Enable bit 3 turns on the light wait period set by the light wait register.
// - Enable bit 4 turns on the proximity wait period set by its own wait register.
// - Light integration lasts the register value plus one steps of 2.78 ms.
// - Integration is a down counter loaded from its register that ends at zero.
// - The top light count is 1024 per step minus one, capped at 65535.
// - A proximity sample lasts the register value plus one times 88 us, reset 0x1F.
// - Light wait is a down counter of the register value plus one 2.78 ms steps.
// - With long wait selected the light wait lasts twelve times as long.
`timescale 1ns/1ps
`include "sset_consts.svh"

module sset_enable_timing #(
   parameter int LIGHT_STEP_CYC = `SSET_LIGHT_STEP_NS / `SSET_CLK_PERIOD_NS,
   parameter int PROX_STEP_CYC = `SSET_PROX_STEP_NS / `SSET_CLK_PERIOD_NS
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic long_wait_select,
   output logic osc_converter_on,
   output logic light_function_enable,
   output logic proximity_function_enable,
   output logic light_wait_enable,
   output logic prox_wait_enable,
   output logic [3:0] timer_active,
   output logic [3:0] timer_done,
   output logic [15:0] light_max_count
);

   // =======================================================================
   // Elaboration checks
   if (LIGHT_STEP_CYC < 1 || LIGHT_STEP_CYC >= (1 << 20)) begin : g_chk_a
      $error("LIGHT_STEP_CYC out of range");
   end
   if (PROX_STEP_CYC < 1 || PROX_STEP_CYC >= (1 << 20)) begin : g_chk_p
      $error("PROX_STEP_CYC out of range");
   end

   // =======================================================================
   // Functions
   function automatic sset_pkg::sset_count_t sset_max(input sset_pkg::sset_byte_t steps);
      logic [17:0] full;
      full = ({10'h000, steps} + 18'h00001) * 18'(`SSET_COUNT_PER_STEP) - 18'h00001;
      if (steps >= `SSET_FULL_SCALE_STEP) begin
         sset_max = `SSET_COUNT_MAX;
      end else begin
         sset_max = full[15:0];
      end
   endfunction

   function automatic sset_pkg::sset_byte_t sset_read(input logic [7:0] a,
         input sset_pkg::sset_byte_t en, input sset_pkg::sset_byte_t it,
         input sset_pkg::sset_byte_t pr, input sset_pkg::sset_byte_t lw,
         input sset_pkg::sset_byte_t pw);
      case (a)
         `SSET_ADDR_ENABLE: sset_read = en;
         `SSET_ADDR_INTEG: sset_read = it;
         `SSET_ADDR_PSAMPLE: sset_read = pr;
         `SSET_ADDR_LWAIT: sset_read = lw;
         `SSET_ADDR_PWAIT: sset_read = pw;
         default: sset_read = 8'h00;
      endcase
   endfunction

   // =======================================================================
   // Registers
   sset_pkg::sset_byte_t en_r, en_nxt, integ_r, integ_nxt, psample_r, psample_nxt;
   sset_pkg::sset_byte_t lwait_r, lwait_nxt, pwait_r, pwait_nxt, rdata_r, rdata_nxt;
   sset_pkg::sset_count_t max_r, max_nxt;
   logic [3:0] go;
   logic [3:0] start;
   sset_pkg::sset_byte_t ld [4];
   logic [3:0] mul_ld [4];

   always_comb begin
      en_nxt = en_r;
      integ_nxt = integ_r;
      psample_nxt = psample_r;
      lwait_nxt = lwait_r;
      pwait_nxt = pwait_r;
      rdata_nxt = rdata_r;
      if (reg_wr) begin
         // All bits stored as written; upper enable bits are left to software
         unique case (reg_addr)
            `SSET_ADDR_ENABLE: en_nxt = reg_wdata;
            `SSET_ADDR_INTEG: integ_nxt = reg_wdata;
            `SSET_ADDR_PSAMPLE: psample_nxt = reg_wdata;
            `SSET_ADDR_LWAIT: lwait_nxt = reg_wdata;
            `SSET_ADDR_PWAIT: pwait_nxt = reg_wdata;
            default: ;
         endcase
      end
      if (reg_rd) begin
         rdata_nxt = sset_read(reg_addr, en_r, integ_r, psample_r, lwait_r, pwait_r);
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         en_r <= `SSET_RST_ENABLE;
         integ_r <= `SSET_RST_INTEG;
         psample_r <= `SSET_RST_PSAMPLE;
         lwait_r <= `SSET_RST_LWAIT;
         pwait_r <= `SSET_RST_PWAIT;
         rdata_r <= 8'h00;
      end else begin
         en_r <= en_nxt;
         integ_r <= integ_nxt;
         psample_r <= psample_nxt;
         lwait_r <= lwait_nxt;
         pwait_r <= pwait_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   assign reg_rdata = rdata_r;
   assign osc_converter_on = en_r[`SSET_EN_OSC];
   assign light_function_enable = en_r[`SSET_EN_LIGHT];
   assign proximity_function_enable = en_r[`SSET_EN_PROX];
   assign light_wait_enable = en_r[`SSET_EN_LWAIT];
   assign prox_wait_enable = en_r[`SSET_EN_PWAIT];

   // =======================================================================
   // Channel steering: 0 integration, 1 prox sample, 2 light wait, 3 prox wait
   always_comb begin
      go[0] = en_r[`SSET_EN_OSC] & en_r[`SSET_EN_LIGHT];
      go[1] = en_r[`SSET_EN_OSC] & en_r[`SSET_EN_PROX];
      go[2] = go[0] & en_r[`SSET_EN_LWAIT];
      go[3] = go[1] & en_r[`SSET_EN_PWAIT];
      ld[0] = integ_r;
      ld[1] = psample_r;
      ld[2] = lwait_r;
      ld[3] = pwait_r;
      mul_ld[0] = 4'h0;
      mul_ld[1] = 4'h0;
      mul_ld[2] = long_wait_select ? 4'(`SSET_LONG_WAIT_MULT - 1) : 4'h0;
      mul_ld[3] = 4'h0;
   end

   // =======================================================================
   // Repeating down counters
   for (genvar i = 0; i < 4; i++) begin : gen_ch
      localparam logic [19:0] STEP_M1 = (i == 1) ? 20'(PROX_STEP_CYC - 1)
                                                 : 20'(LIGHT_STEP_CYC - 1);
      logic run_r, run_nxt, done_r, done_nxt, start_w;
      logic [19:0] pre_r, pre_nxt;
      logic [7:0] cnt_r, cnt_nxt;
      logic [3:0] mul_r, mul_nxt;

      always_comb begin
         run_nxt = run_r;
         pre_nxt = pre_r;
         cnt_nxt = cnt_r;
         mul_nxt = mul_r;
         done_nxt = 1'b0;
         start_w = 1'b0;
         if (!go[i]) begin
            // Idle while powered down or disabled
            run_nxt = 1'b0;
            pre_nxt = 20'h00000;
            cnt_nxt = 8'h00;
            mul_nxt = 4'h0;
         end else if (!run_r) begin
            // Register value taken here and again at each terminal count reload
            start_w = 1'b1;
            run_nxt = 1'b1;
            pre_nxt = STEP_M1;
            cnt_nxt = ld[i];
            mul_nxt = mul_ld[i];
         end else if (pre_r != 20'h00000) begin
            pre_nxt = pre_r - 20'h00001;
         end else begin
            pre_nxt = STEP_M1;
            if (mul_r != 4'h0) begin
               mul_nxt = mul_r - 4'h1;
            end else begin
               mul_nxt = mul_ld[i];
               if (cnt_r != 8'h00) begin
                  cnt_nxt = cnt_r - 8'h01;
               end else begin
                  // Terminal count ends the period and reloads
                  done_nxt = 1'b1;
                  start_w = 1'b1;
                  cnt_nxt = ld[i];
               end
            end
         end
      end

      always_ff @(posedge clock) begin
         if (rst) begin
            run_r <= 1'b0;
            pre_r <= 20'h00000;
            cnt_r <= 8'h00;
            mul_r <= 4'h0;
            done_r <= 1'b0;
         end else begin
            run_r <= run_nxt;
            pre_r <= pre_nxt;
            cnt_r <= cnt_nxt;
            mul_r <= mul_nxt;
            done_r <= done_nxt;
         end
      end

      assign timer_active[i] = run_r;
      assign timer_done[i] = done_r;
      assign start[i] = start_w;
   end

   // =======================================================================
   // Top reachable light count
   always_comb begin
      max_nxt = max_r;
      if (start[0]) begin
         max_nxt = sset_max(integ_r);
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         max_r <= 16'h0000;
      end else begin
         max_r <= max_nxt;
      end
   end

   assign light_max_count = max_r;

   // =======================================================================
   // Assertions
   sequence s_integ_last;
      gen_ch[0].run_r && gen_ch[0].pre_r == 20'h00000 && gen_ch[0].mul_r == 4'h0
         && gen_ch[0].cnt_r == 8'h00;
   endsequence

   sequence s_integ_end;
      ##1 timer_done[0] && gen_ch[0].cnt_r == $past(integ_r);
   endsequence

   AST_OSC_OFF: assert property (@(posedge clock) disable iff (rst)
      !en_r[`SSET_EN_OSC] |=> timer_active == 4'h0 && timer_done == 4'h0)
      else $error("timer running with oscillator off");

   AST_LIGHT_START: assert property (@(posedge clock) disable iff (rst)
      go[0] && !gen_ch[0].run_r |=> gen_ch[0].run_r && gen_ch[0].cnt_r == $past(integ_r))
      else $error("integration did not start from its register");

   AST_PROX_START: assert property (@(posedge clock) disable iff (rst)
      go[1] && !gen_ch[1].run_r |=> gen_ch[1].cnt_r == $past(psample_r)
      && gen_ch[1].pre_r == 20'(PROX_STEP_CYC - 1))
      else $error("prox sample did not start from its register");

   AST_LWAIT_GATE: assert property (@(posedge clock) disable iff (rst)
      timer_active[2] |-> $past(en_r[`SSET_EN_LWAIT]) && $past(go[0]))
      else $error("light wait ran while disabled");

   AST_PWAIT_GATE: assert property (@(posedge clock) disable iff (rst)
      timer_active[3] |-> $past(en_r[`SSET_EN_PWAIT]) && $past(go[1]))
      else $error("prox wait ran while disabled");

   AST_INTEG_END: assert property (@(posedge clock) disable iff (rst)
      s_integ_last and go[0] |-> s_integ_end)
      else $error("integration did not end at terminal count");

   AST_MAX_COUNT: assert property (@(posedge clock) disable iff (rst)
      $rose(timer_active[0]) |-> light_max_count == sset_max($past(integ_r)))
      else $error("top light count wrong");

   AST_PSAMPLE_RESET: assert property (@(posedge clock)
      rst |=> psample_r == `SSET_RST_PSAMPLE)
      else $error("prox sample register reset value wrong");

   AST_LWAIT_START: assert property (@(posedge clock) disable iff (rst)
      go[2] && !gen_ch[2].run_r |=> gen_ch[2].cnt_r == $past(lwait_r))
      else $error("light wait did not start from its register");

   AST_LONG_WAIT: assert property (@(posedge clock) disable iff (rst)
      $rose(timer_active[2]) |-> gen_ch[2].mul_r == ($past(long_wait_select) ? 4'hB : 4'h0))
      else $error("long wait multiplier wrong");

   AST_HOLD_LOAD: assert property (@(posedge clock) disable iff (rst)
      go[0] && gen_ch[0].run_r && gen_ch[0].cnt_r != 8'h00 ##1 go[0]
      |-> gen_ch[0].cnt_r <= $past(gen_ch[0].cnt_r))
      else $error("integration count reloaded mid period");

endmodule

// ==== testbench/sset_enable_timing_tb.sv ====
// Purpose: Self-checking bench for the enable register and measurement timers
// Assumes: Short step counts (light 3 cycles, proximity 2 cycles) for a fast run
// Notes: Inputs change on the falling edge; outputs are sampled there too
`timescale 1ns/1ps
`include "sset_consts.svh"

module sset_enable_timing_tb;
   localparam int LS = 3;
   localparam int PS = 2;
   typedef struct {logic [7:0] it, pr, lw, pw; logic lg; int p [4]; logic [15:0] mx;} sset_row_s;

   // ===========================================================================
   // Signals
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic reg_wr = 1'b0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_rd = 1'b0;
   logic long_wait_select = 1'b0;
   logic [7:0] reg_rdata;
   logic osc_converter_on, light_function_enable, proximity_function_enable;
   logic light_wait_enable, prox_wait_enable;
   logic [3:0] timer_active, timer_done;
   logic [15:0] light_max_count;
   wire [4:0] en_bits = {prox_wait_enable, light_wait_enable, proximity_function_enable,
                         light_function_enable, osc_converter_on};
   int err_total = 0;
   int num_checks = 0;
   sset_row_s rows [4];
   int st [4];
   int dn [4];
   logic [7:0] v;
   logic [7:0] ra [5] = '{8'h81, 8'h82, 8'h83, 8'hA9, 8'h84};
   logic [7:0] rv [5] = '{8'hA5, 8'h5A, 8'hFF, 8'h3C, 8'h77};
   logic [7:0] ev [5] = '{8'h01, 8'h04, 8'h08, 8'h10, 8'h12};
   int d0, d1;

   always #5 clock = ~clock;

   sset_enable_timing #(.LIGHT_STEP_CYC(LS), .PROX_STEP_CYC(PS)) dut (
      .clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .long_wait_select(long_wait_select), .osc_converter_on(osc_converter_on),
      .light_function_enable(light_function_enable),
      .proximity_function_enable(proximity_function_enable),
      .light_wait_enable(light_wait_enable), .prox_wait_enable(prox_wait_enable),
      .timer_active(timer_active), .timer_done(timer_done), .light_max_count(light_max_count));

   // ===========================================================================
   // Tasks
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED t=%0t seen=%0h exp=%0h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clock);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clock);
      reg_wr = 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clock);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge clock);
      reg_rd = 1'b0;
      @(negedge clock);
      d = reg_rdata;
   endtask

   task automatic watch(input int win);
      for (int i = 0; i < 4; i++) begin
         st[i] = -1;
         dn[i] = -1;
      end
      for (int c = 0; c < win; c++) begin
         @(negedge clock);
         for (int i = 0; i < 4; i++) begin
            if (st[i] < 0 && timer_active[i] === 1'b1) st[i] = c;
            if (dn[i] < 0 && timer_done[i] === 1'b1) dn[i] = c;
         end
      end
   endtask

   task automatic final_report;
      $display("Checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // ===========================================================================
   // Main sequence
   initial begin
      rows[0] = '{8'h01, 8'h02, 8'h00, 8'h01, 1'b0, '{2*LS, 3*PS, LS, 2*LS}, 16'h07FF};
      rows[1] = '{8'h00, 8'h00, 8'h01, 8'h00, 1'b1,
                  '{LS, PS, 2*`SSET_LONG_WAIT_MULT*LS, LS}, 16'h03FF};
      rows[2] = '{8'h3F, 8'h1F, 8'h02, 8'h03, 1'b0,
                  '{64*LS, 32*PS, 3*LS, 4*LS}, 16'hFFFF};
      rows[3] = '{8'h11, 8'h05, 8'h00, 8'h00, 1'b1,
                  '{18*LS, 6*PS, `SSET_LONG_WAIT_MULT*LS, LS}, 16'h47FF};
      repeat (3) @(negedge clock);
      rst = 1'b0;
      check(en_bits, 5'h00);
      rd(`SSET_ADDR_ENABLE, v);
      check(v, `SSET_RST_ENABLE);
      rd(`SSET_ADDR_INTEG, v);
      check(v, `SSET_RST_INTEG);
      rd(`SSET_ADDR_PSAMPLE, v);
      check(v, `SSET_RST_PSAMPLE);
      rd(`SSET_ADDR_LWAIT, v);
      check(v, `SSET_RST_LWAIT);
      rd(`SSET_ADDR_PWAIT, v);
      check(v, `SSET_RST_PWAIT);
      // Read back, unmapped place last
      for (int i = 0; i < 5; i++) begin
         wr(ra[i], rv[i]);
         rd(ra[i], v);
         check(v, (i == 4) ? 8'h00 : rv[i]);
      end
      // Each enable bit to its output; reserved bits written as zero
      for (int i = 0; i < 5; i++) begin
         wr(`SSET_ADDR_ENABLE, ev[i]);
         check(en_bits, ev[i][4:0]);
         @(negedge clock);
         check(timer_active, 4'h0);
      end
      // Timing rows, registers set before the function enables
      foreach (rows[r]) begin
         wr(`SSET_ADDR_ENABLE, 8'h00);
         wr(`SSET_ADDR_INTEG, rows[r].it);
         wr(`SSET_ADDR_PSAMPLE, rows[r].pr);
         wr(`SSET_ADDR_LWAIT, rows[r].lw);
         wr(`SSET_ADDR_PWAIT, rows[r].pw);
         long_wait_select = rows[r].lg;
         wr(`SSET_ADDR_ENABLE, 8'h1F);
         watch(220);
         for (int i = 0; i < 4; i++) check(dn[i] - st[i], rows[r].p[i]);
         check(light_max_count, rows[r].mx);
      end
      // Oscillator dropped mid period stops every timer
      wr(`SSET_ADDR_ENABLE, 8'h1E);
      @(negedge clock);
      check(timer_active, 4'h0);
      watch(40);
      for (int i = 0; i < 4; i++) check(st[i], -1);
      // New integration value written mid period waits for the next period
      wr(`SSET_ADDR_INTEG, 8'h01);
      wr(`SSET_ADDR_ENABLE, 8'h1B);
      repeat (3) @(negedge clock);
      wr(`SSET_ADDR_INTEG, 8'h03);
      d0 = -1;
      d1 = -1;
      for (int c = 0; c < 40; c++) begin
         @(negedge clock);
         if (timer_done[0] === 1'b1 && d0 >= 0 && d1 < 0) d1 = c;
         if (timer_done[0] === 1'b1 && d0 < 0) d0 = c;
      end
      check(d0 < 2 * LS, 1'b1);
      check(d1 - d0, 4 * LS);
      check(light_max_count, 16'h0FFF);
      // Reset in mid run returns registers, read data and timers to reset state
      rd(`SSET_ADDR_ENABLE, v);
      check(v, 8'h1B);
      rst = 1'b1;
      repeat (3) @(negedge clock);
      rst = 1'b0;
      check(en_bits, 5'h00);
      check(timer_active, 4'h0);
      check(timer_done, 4'h0);
      check(reg_rdata, 8'h00);
      check(light_max_count, 16'h0000);
      rd(`SSET_ADDR_INTEG, v);
      check(v, `SSET_RST_INTEG);
      rd(`SSET_ADDR_PSAMPLE, v);
      check(v, `SSET_RST_PSAMPLE);
      final_report();
   end

   // ===========================================================================
   // Watchdog
   initial begin
      repeat (20000) @(posedge clock);
      err_total++;
      final_report();
   end
endmodule
